// ==== rtl/gss_pkg.sv ====
package gss_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] GSS_RESERVED_SLOT_A_OFS  = 8'h50;
  localparam logic [7:0] GSS_RESERVED_SLOT_B_OFS  = 8'h51;
  localparam logic [7:0] GSS_PIN1_SOURCE_SEL_OFS  = 8'h52;
  localparam logic [7:0] GSS_PIN0_SOURCE_SEL_OFS  = 8'h53;
  localparam logic [7:0] GSS_RESERVED_SLOT_C_OFS  = 8'h54;
  localparam logic [7:0] GSS_PIN2_SOURCE_SEL_OFS  = 8'h55;
  localparam logic [7:0] GSS_PIN_LEVEL_OFS        = 8'h56;

  localparam logic [7:0] GSS_REG_RESET            = 8'h00;
  localparam logic [7:0] GSS_RDATA_UNMAPPED       = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned GSS_SRC_CODE_LSB        = 0;
  localparam int unsigned GSS_SRC_CODE_W          = 5;
  localparam int unsigned GSS_PIN0_LEVEL_BIT      = 3;

  // ----------------------------------------------------------------
  // Source codes for general pin zero
  // ----------------------------------------------------------------
  localparam logic [4:0] GSS_SRC_OFF              = 5'h00;
  localparam logic [4:0] GSS_SRC_REG_LEVEL        = 5'h02;
  localparam logic [4:0] GSS_SRC_AUTOMUTE_BOTH    = 5'h03;
  localparam logic [4:0] GSS_SRC_AUTOMUTE_L       = 5'h04;
  localparam logic [4:0] GSS_SRC_AUTOMUTE_R       = 5'h05;
  localparam logic [4:0] GSS_SRC_CLK_INVALID      = 5'h06;
  localparam logic [4:0] GSS_SRC_SERIAL_OUT       = 5'h07;
  localparam logic [4:0] GSS_SRC_ANA_MUTE_L_N     = 5'h08;
  localparam logic [4:0] GSS_SRC_ANA_MUTE_R_N     = 5'h09;
  localparam logic [4:0] GSS_SRC_PLL_LOCK         = 5'h0A;
  localparam logic [4:0] GSS_SRC_CP_CLK           = 5'h0B;
  localparam logic [4:0] GSS_SRC_UV_HIGH          = 5'h0E;
  localparam logic [4:0] GSS_SRC_UV_LOW           = 5'h0F;
  localparam logic [4:0] GSS_SRC_PLL_DIV4         = 5'h10;
  localparam logic [4:0] GSS_SRC_OSC_DIV4         = 5'h11;
  localparam logic [4:0] GSS_SRC_IMP_L            = 5'h12;
  localparam logic [4:0] GSS_SRC_IMP_R            = 5'h13;
  localparam logic [4:0] GSS_SRC_UV_PROTECTION_N  = 5'h14;
  localparam logic [4:0] GSS_SRC_OFFSET_CAL       = 5'h15;
  localparam logic [4:0] GSS_SRC_CLK_ERR          = 5'h16;
  localparam logic [4:0] GSS_SRC_CLK_CHG          = 5'h17;
  localparam logic [4:0] GSS_SRC_CLK_MISS         = 5'h18;
  localparam logic [4:0] GSS_SRC_CLK_HALT         = 5'h19;
  localparam logic [4:0] GSS_SRC_BOOT_DONE        = 5'h1A;
  localparam logic [4:0] GSS_SRC_CP_VALID_N       = 5'h1B;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned GSS_SYNC_STAGES         = 2;
  localparam logic [1:0]  GSS_DIV4_HALF_EDGES     = 2'h2;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } gss_reg_req_t;

  typedef struct packed {
    logic automute_l;
    logic automute_r;
    logic ana_mute_l_n;
    logic ana_mute_r_n;
    logic pll_lock;
    logic cp_clk;
    logic uv_high;
    logic uv_low;
    logic imp_l;
    logic imp_r;
    logic undervoltage_protection_n;
    logic offset_cal;
    logic clk_err;
    logic clk_chg;
    logic clk_miss;
    logic clk_halt;
    logic boot_done;
    logic cp_valid_n;
    logic pll_clk;
    logic osc_clk;
  } gss_status_t;

  localparam int unsigned GSS_STATUS_W = $bits(gss_status_t);

endpackage

// ==== rtl/gss_sync.sv ====
`timescale 1ns/1ns

module gss_sync #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  // Asynchronous levels in, synchronised levels out
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta_q;

  // The first stage feeds the second stage only.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      meta_q <= '0;
      sync_o <= '0;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule // gss_sync

// ==== rtl/gss_clkdiv.sv ====
`timescale 1ns/1ns

module gss_clkdiv
  import gss_pkg::*;
(
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // Sampled source clock and divided level
  input  wire logic src_i,
  output logic      div_o
);

  logic       src_q;
  logic [1:0] edge_cnt_q;
  logic       rise;

  // The source is already synchronised, so it must run below half of clk_i.
  assign rise = src_i & ~src_q;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      src_q      <= 1'b0;
      edge_cnt_q <= 2'h0;
      div_o      <= 1'b0;
    end else begin
      src_q <= src_i;
      if (rise) begin
        if (edge_cnt_q == GSS_DIV4_HALF_EDGES - 2'h1) begin
          edge_cnt_q <= 2'h0;
          div_o      <= ~div_o;
        end else begin
          edge_cnt_q <= edge_cnt_q + 2'h1;
        end
      end
    end
  end

endmodule // gss_clkdiv

// ==== rtl/gss_top.sv ====
`timescale 1ns/1ns

// What this block does
// R01: Five-bit read/write selector in bits 4:0 picks the pin zero source.
// R02: Software sets pin zero to output elsewhere before the source shows.
// R03: Code 0110 drives clock invalid: error OR changing OR missing.
// R04: Code 0111 routes the serial audio data output onto the pin.
// R05: Codes 1000 and 1001 drive left and right analog mute, active low.
// R06: Code 1010 drives the phase-locked loop lock indication.
// R07: Code 1011 drives the charge pump clock.
// R08: Codes 1110 and 1111 drive the 0.7 and 0.3 supply undervoltage flags.
// R09: Codes 10010 and 10011 drive left and right impedance sense flags.
// R10: Code 10100 drives internal undervoltage protection, low below about 2.7 V.
// R11: Code 10101 drives the flag held during offset calibration.
// R12: Code 10110 drives the clock error flag.
// R13: Codes 10111 and 11000 drive clock changing and clock missing flags.
// R14: Code 11001 drives the clock halt detection flag.
// R15: Code 11010 drives the signal processor boot done flag.
// R16: Code 11011 drives charge pump voltage valid, active low.
// R17: Codes 10000 and 10001 drive loop clock and oscillator clock divided by four.
// R18: Unassigned codes, reserved 1100 and 1101 included, drive constant zero.
// R19: Reserved registers reset to zero, accept writes, affect nothing.
// R20: Codes 0011, 0100, 0101 drive auto-mute both, left and right.
// R21: Code 0010 drives the level bit 3 of the level register.
module gss_top (
  // Clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_n_i,
  // Register access
  input  wire gss_pkg::gss_reg_req_t reg_req_i,
  output logic [7:0]                reg_rdata_o,
  output logic                      reg_rvalid_o,
  // Internal status sources from other domains
  input  wire gss_pkg::gss_status_t status_i,
  // Serial audio data output, same clock domain
  input  wire logic                 serial_audio_out_i,
  // Pin zero level and the selector codes for pins zero, one and two
  output logic                      general_pin_zero_o,
  output logic [4:0]                pin0_source_code_o,
  output logic [4:0]                pin1_source_code_o,
  output logic [4:0]                pin2_source_code_o
);

  import gss_pkg::*;

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [7:0] reserved_slot_a_q;
  logic [7:0] reserved_slot_b_q;
  logic [7:0] pin1_source_select_q;
  logic [7:0] pin0_source_select_q;
  logic [7:0] reserved_slot_c_q;
  logic [7:0] pin2_source_select_q;
  logic [7:0] pin_level_q;

  logic [7:0] rdata_d;
  logic       pin_d;
  logic       pin0_register_level;
  logic [4:0] pin0_source_code;

  // ----------------------------------------------------------------
  // Synchronised sources
  // ----------------------------------------------------------------
  gss_status_t status_s;
  logic        pll_div4;
  logic        osc_div4;
  logic        clk_invalid;
  logic        automute_both;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  function automatic logic is_addr(input logic [7:0] addr, input logic [7:0] ofs);
    is_addr = (addr == ofs);
  endfunction

  function automatic logic [4:0] code_of(input logic [7:0] sel);
    code_of = sel[GSS_SRC_CODE_LSB +: GSS_SRC_CODE_W];
  endfunction

  // ----------------------------------------------------------------
  // Crossing into the register clock
  // ----------------------------------------------------------------
  // Analog flags and foreign clocks are all asynchronous to clk_i, so the whole
  // bundle takes two flops. The pin therefore lags a flag by up to three cycles.
  gss_sync #(
    .W (GSS_STATUS_W)
  ) u_status_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .async_i (status_i),
    .sync_o  (status_s)
  );

  // The divided clocks are only faithful while the source runs well below
  // half of clk_i; a faster source aliases, a trade accepted for one clock.
  gss_clkdiv u_pll_div (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .src_i   (status_s.pll_clk),
    .div_o   (pll_div4)
  );

  gss_clkdiv u_osc_div (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .src_i   (status_s.osc_clk),
    .div_o   (osc_div4)
  );

  // ----------------------------------------------------------------
  // Derived indications
  // ----------------------------------------------------------------
  assign clk_invalid   = status_s.clk_err | status_s.clk_chg | status_s.clk_miss; // [R03]
  assign automute_both = status_s.automute_l & status_s.automute_r;                // [R20]

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // Reserved slots hold what is written and feed nothing but read-back.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      reserved_slot_a_q <= GSS_REG_RESET; // [R19]
      reserved_slot_b_q <= GSS_REG_RESET;
      reserved_slot_c_q <= GSS_REG_RESET;
    end else if (reg_req_i.wr) begin
      if (is_addr(reg_req_i.addr, GSS_RESERVED_SLOT_A_OFS)) begin
        reserved_slot_a_q <= reg_req_i.wdata; // [R19]
      end
      if (is_addr(reg_req_i.addr, GSS_RESERVED_SLOT_B_OFS)) begin
        reserved_slot_b_q <= reg_req_i.wdata; // [R19]
      end
      if (is_addr(reg_req_i.addr, GSS_RESERVED_SLOT_C_OFS)) begin
        reserved_slot_c_q <= reg_req_i.wdata; // [R19]
      end
    end
  end

  // Whole bytes are stored, so the reserved upper bits read back as written.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pin0_source_select_q <= GSS_REG_RESET;
      pin1_source_select_q <= GSS_REG_RESET;
      pin2_source_select_q <= GSS_REG_RESET;
    end else if (reg_req_i.wr) begin
      if (is_addr(reg_req_i.addr, GSS_PIN0_SOURCE_SEL_OFS)) begin
        pin0_source_select_q <= reg_req_i.wdata; // [R01]
      end
      if (is_addr(reg_req_i.addr, GSS_PIN1_SOURCE_SEL_OFS)) begin
        pin1_source_select_q <= reg_req_i.wdata;
      end
      if (is_addr(reg_req_i.addr, GSS_PIN2_SOURCE_SEL_OFS)) begin
        pin2_source_select_q <= reg_req_i.wdata;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pin_level_q <= GSS_REG_RESET;
    end else if (reg_req_i.wr && is_addr(reg_req_i.addr, GSS_PIN_LEVEL_OFS)) begin
      pin_level_q <= reg_req_i.wdata; // [R21]
    end
  end

  assign pin0_source_code    = code_of(pin0_source_select_q); // [R01]
  assign pin0_register_level = pin_level_q[GSS_PIN0_LEVEL_BIT];

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  always_comb begin
    rdata_d = GSS_RDATA_UNMAPPED;
    case (reg_req_i.addr)
      GSS_RESERVED_SLOT_A_OFS: rdata_d = reserved_slot_a_q;
      GSS_RESERVED_SLOT_B_OFS: rdata_d = reserved_slot_b_q;
      GSS_PIN1_SOURCE_SEL_OFS: rdata_d = pin1_source_select_q;
      GSS_PIN0_SOURCE_SEL_OFS: rdata_d = pin0_source_select_q; // [R01]
      GSS_RESERVED_SLOT_C_OFS: rdata_d = reserved_slot_c_q;
      GSS_PIN2_SOURCE_SEL_OFS: rdata_d = pin2_source_select_q;
      GSS_PIN_LEVEL_OFS:       rdata_d = pin_level_q;
      default:                 rdata_d = GSS_RDATA_UNMAPPED;
    endcase
  end

  // A read returns the value held before any write in the same cycle.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      reg_rdata_o  <= GSS_RDATA_UNMAPPED;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_req_i.rd;
      if (reg_req_i.rd) begin
        reg_rdata_o <= rdata_d;
      end
    end
  end

  // ----------------------------------------------------------------
  // Source selection
  // ----------------------------------------------------------------
  always_comb begin
    pin_d = 1'b0;
    case (pin0_source_code)
      GSS_SRC_REG_LEVEL:     pin_d = pin0_register_level;     // [R21]
      GSS_SRC_AUTOMUTE_BOTH: pin_d = automute_both;           // [R20]
      GSS_SRC_AUTOMUTE_L:    pin_d = status_s.automute_l;     // [R20]
      GSS_SRC_AUTOMUTE_R:    pin_d = status_s.automute_r;     // [R20]
      GSS_SRC_CLK_INVALID:   pin_d = clk_invalid;             // [R03]
      GSS_SRC_SERIAL_OUT:    pin_d = serial_audio_out_i;      // [R04]
      GSS_SRC_ANA_MUTE_L_N:  pin_d = status_s.ana_mute_l_n;   // [R05]
      GSS_SRC_ANA_MUTE_R_N:  pin_d = status_s.ana_mute_r_n;   // [R05]
      GSS_SRC_PLL_LOCK:      pin_d = status_s.pll_lock;       // [R06]
      GSS_SRC_CP_CLK:        pin_d = status_s.cp_clk;         // [R07]
      GSS_SRC_UV_HIGH:       pin_d = status_s.uv_high;        // [R08]
      GSS_SRC_UV_LOW:        pin_d = status_s.uv_low;         // [R08]
      GSS_SRC_PLL_DIV4:      pin_d = pll_div4;                // [R17]
      GSS_SRC_OSC_DIV4:      pin_d = osc_div4;                // [R17]
      GSS_SRC_IMP_L:         pin_d = status_s.imp_l;          // [R09]
      GSS_SRC_IMP_R:         pin_d = status_s.imp_r;          // [R09]
      GSS_SRC_UV_PROTECTION_N: pin_d = status_s.undervoltage_protection_n; // [R10]
      GSS_SRC_OFFSET_CAL:    pin_d = status_s.offset_cal;     // [R11]
      GSS_SRC_CLK_ERR:       pin_d = status_s.clk_err;        // [R12]
      GSS_SRC_CLK_CHG:       pin_d = status_s.clk_chg;        // [R13]
      GSS_SRC_CLK_MISS:      pin_d = status_s.clk_miss;       // [R13]
      GSS_SRC_CLK_HALT:      pin_d = status_s.clk_halt;       // [R14]
      GSS_SRC_BOOT_DONE:     pin_d = status_s.boot_done;      // [R15]
      GSS_SRC_CP_VALID_N:    pin_d = status_s.cp_valid_n;     // [R16]
      default:               pin_d = 1'b0;                    // [R18]
    endcase
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  // The pin level is registered so that a selector change never glitches it.
  // Direction lives in another block; software must enable the pin there. [R02]
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      general_pin_zero_o <= 1'b0;
    end else begin
      general_pin_zero_o <= pin_d;
    end
  end

  assign pin0_source_code_o = pin0_source_code;
  assign pin1_source_code_o = code_of(pin1_source_select_q);
  assign pin2_source_code_o = code_of(pin2_source_select_q);

endmodule // gss_top

// ==== dv/gss_pin_monitor.sv ====
`timescale 1ns/1ns

module gss_pin_monitor (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // Watched pin and count control
  input  wire logic        pin_i,
  input  wire logic        clr_i,
  output logic      [15:0] rise_count_o
);
  // ----------------------------------------------------------------
  // Board-side edge counter
  // ----------------------------------------------------------------
  logic prev_q;

  // The board assumes software already set the pin to output, so the level is watched from reset on.
  always_ff @(posedge clk_i) begin
    prev_q <= rst_n_i ? pin_i : 1'b0;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i || clr_i) begin
      rise_count_o <= 16'h0000;
    end else if (pin_i && !prev_q) begin
      rise_count_o <= rise_count_o + 16'h0001;
    end
  end
endmodule // gss_pin_monitor

// ==== dv/gss_props.sv ====
`timescale 1ns/1ns

module gss_props (
  input  wire logic                  clk_i,
  input  wire logic                  rst_n_i,
  input  wire gss_pkg::gss_reg_req_t reg_req_i,
  input  wire logic [7:0]            reg_rdata_o,
  input  wire logic                  reg_rvalid_o,
  input  wire gss_pkg::gss_status_t  status_i,
  input  wire logic                  serial_audio_out_i,
  input  wire logic                  general_pin_zero_o,
  input  wire logic [4:0]            pin0_source_code_o,
  input  wire logic [4:0]            pin1_source_code_o,
  input  wire logic [4:0]            pin2_source_code_o
);
  import gss_pkg::*;
  // ----------------------------------------------------------------
  // Pin and register relations
  // ----------------------------------------------------------------
  // Flags cross two sync flops, so a flag check needs three clean edges since reset.
  logic [1:0] up_q;
  logic       sel_wr;
  assign sel_wr = reg_req_i.wr && reg_req_i.addr == 8'h53;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) up_q <= 2'h0;
    else if (up_q != 2'h3) up_q <= up_q + 2'h1;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_rd_answer; reg_req_i.rd |=> reg_rvalid_o; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
  property p_no_answer; !reg_req_i.rd |=> !reg_rvalid_o && $stable(reg_rdata_o); endproperty
  a_no_answer: assert property (p_no_answer) else $error("answer without read");
  property p_code_write; sel_wr |=> pin0_source_code_o == $past(reg_req_i.wdata[4:0]); endproperty
  a_code_write: assert property (p_code_write) else $error("selector write lost");
  property p_code_hold; !sel_wr |=> $stable(pin0_source_code_o); endproperty
  a_code_hold: assert property (p_code_hold) else $error("selector changed");
  property p_serial; pin0_source_code_o == 5'h07 |=> general_pin_zero_o == $past(serial_audio_out_i); endproperty
  a_serial: assert property (p_serial) else $error("serial data not on pin");
  property p_unassigned;
    pin0_source_code_o inside {5'h00, 5'h01, 5'h0C, 5'h0D, [5'h1C:5'h1F]} |=> !general_pin_zero_o;
  endproperty
  a_unassigned: assert property (p_unassigned) else $error("unassigned code not low");
  property p_clk_invalid;
    up_q == 2'h3 && $past(pin0_source_code_o) == 5'h06 |->
      general_pin_zero_o == ($past(status_i.clk_err, 3) | $past(status_i.clk_chg, 3) | $past(status_i.clk_miss, 3));
  endproperty
  a_clk_invalid: assert property (p_clk_invalid) else $error("clock invalid wrong");
  property p_automute;
    up_q == 2'h3 && $past(pin0_source_code_o) == 5'h03 |->
      general_pin_zero_o == ($past(status_i.automute_l, 3) & $past(status_i.automute_r, 3));
  endproperty
  a_automute: assert property (p_automute) else $error("auto-mute both wrong");
  property p_cp_valid;
    up_q == 2'h3 && $past(pin0_source_code_o) == 5'h1B |-> general_pin_zero_o == $past(status_i.cp_valid_n, 3);
  endproperty
  a_cp_valid: assert property (p_cp_valid) else $error("pump valid wrong");
endmodule // gss_props

bind gss_top gss_props u_props (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_req_i(reg_req_i), .reg_rdata_o(reg_rdata_o),
  .reg_rvalid_o(reg_rvalid_o), .status_i(status_i), .serial_audio_out_i(serial_audio_out_i),
  .general_pin_zero_o(general_pin_zero_o), .pin0_source_code_o(pin0_source_code_o),
  .pin1_source_code_o(pin1_source_code_o), .pin2_source_code_o(pin2_source_code_o));

// ==== dv/tb_top.sv ====
`timescale 1ns/1ns

module tb_top;
  import gss_pkg::*;
  // ----------------------------------------------------------------
  // Bench
  // ----------------------------------------------------------------
  logic         clk_i, rst_n_i, ser, rvalid, pin, clr;
  gss_reg_req_t req;
  gss_status_t  st, s;
  logic [7:0]   rdata;
  logic [4:0]   c0, c1, c2;
  logic [15:0]  rises;
  int           err_total, check_count;

  gss_top u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_req_i(req), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
    .status_i(st), .serial_audio_out_i(ser), .general_pin_zero_o(pin), .pin0_source_code_o(c0),
    .pin1_source_code_o(c1), .pin2_source_code_o(c2));
  gss_pin_monitor u_mon (.clk_i(clk_i), .rst_n_i(rst_n_i), .pin_i(pin), .clr_i(clr), .rise_count_o(rises));

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_i);
    req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_i);
    req.rd <= 1'b0;
    @(negedge clk_i);
    chk({7'h00, rvalid}, 8'h01);
    chk(rdata, exp);
  endtask

  // Four edges cover the two sync flops and the pin flop.
  task automatic drive(input gss_status_t v, input logic b);
    @(posedge clk_i);
    st  <= v;
    ser <= b;
    repeat (4) @(posedge clk_i);
    @(negedge clk_i);
  endtask

  function automatic logic pin_exp(input logic [4:0] c, input gss_status_t v, input logic b);
    case (c)
      5'h02: return 1'b1;
      5'h03: return v.automute_l & v.automute_r;
      5'h04: return v.automute_l;
      5'h05: return v.automute_r;
      5'h06: return v.clk_err | v.clk_chg | v.clk_miss;
      5'h07: return b;
      5'h08: return v.ana_mute_l_n;
      5'h09: return v.ana_mute_r_n;
      5'h0A: return v.pll_lock;
      5'h0B: return v.cp_clk;
      5'h0E: return v.uv_high;
      5'h0F: return v.uv_low;
      5'h12: return v.imp_l;
      5'h13: return v.imp_r;
      5'h14: return v.undervoltage_protection_n;
      5'h15: return v.offset_cal;
      5'h16: return v.clk_err;
      5'h17: return v.clk_chg;
      5'h18: return v.clk_miss;
      5'h19: return v.clk_halt;
      5'h1A: return v.boot_done;
      5'h1B: return v.cp_valid_n;
      default: return 1'b0;
    endcase
  endfunction

  task automatic results();
    $display("Counts: %0d checks, %0d mismatches", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    #2000000;
    err_total++;
    results();
  end

  initial begin
    rst_n_i = 1'b0;
    req = '0;
    st = '0;
    ser = 1'b0;
    clr = 1'b0;
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    for (int a = 8'h50; a < 8'h58; a++) rd(8'(a), 8'h00);
    for (int a = 8'h50; a < 8'h58; a++) begin
      wr(8'(a), 8'hA5 ^ 8'(a));
      rd(8'(a), (a == 8'h57) ? 8'h00 : (8'hA5 ^ 8'(a)));
    end
    chk({3'h0, c0}, 8'h16);
    chk({3'h0, c1}, 8'h17);
    chk({3'h0, c2}, 8'h10);
    $display("test registers done");
    wr(8'h53, 8'h02);
    wr(8'h56, 8'hF7);
    for (int a = 0; a < 3; a++) wr((a == 2) ? 8'h54 : 8'(8'h50 + a), 8'hFF);
    drive('1, 1'b1);
    chk({7'h00, pin}, 8'h00);
    wr(8'h56, 8'h08);
    $display("test level done");
    for (int c = 0; c < 32; c++) begin
      if (c != 16 && c != 17) begin
        wr(8'h53, 8'(c));
        for (int p = 0; p < 22; p++) begin
          s = (p == 0) ? '0 : (p == 21) ? '1 : gss_status_t'(20'h00001 << (p - 1));
          s.pll_clk = 1'b0;
          s.osc_clk = 1'b0;
          drive(s, p[0]);
          chk({7'h00, pin}, {7'h00, pin_exp(5'(c), s, p[0])});
        end
      end
    end
    $display("test source map done");
    for (int c = 16; c < 18; c++) begin
      wr(8'h53, 8'(c));
      for (int k = 0; k < 194; k++) begin
        @(posedge clk_i);
        st.pll_clk <= k[2];
        st.osc_clk <= k[3];
        clr <= (k == 64);
      end
      @(negedge clk_i);
      chk(rises[7:0], (c == 16) ? 8'h04 : 8'h02);
    end
    $display("test dividers done");
    results();
  end
endmodule // tb_top
